// ### rtl/bas_pkg.sv
/*
 brake acknowledge supervisor and start-torque selector: shared constants.
 assumes a 10 MHz control clock; times are given in tenths of a second.
*/
`default_nettype none
package bas_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int TENTH_S_CYCLES = CLK_HZ / 10;
	localparam int TIME_W = 10;
	localparam int CNT_W = 30;
	localparam int TORQ_W = 16;
	typedef enum logic [1:0] {BAS_ALARM, BAS_FAULT, BAS_RSVD, BAS_CRANE} bas_react_e;
	localparam logic [1:0] REACT_RESET = 2'h1;
	localparam logic [3:0] SEL_OFF = 4'h0;
	localparam logic [3:0] SEL_MEMORY = 4'h1;
	localparam logic [3:0] SEL_FIXED = 4'h2;
	localparam logic [3:0] SEL_AI1 = 4'h3;
	localparam logic [3:0] SEL_AI6 = 4'h8;
	localparam logic signed [TORQ_W-1:0] FIXED_MAX = 16'sh0145;
	localparam logic signed [TORQ_W-1:0] FIXED_MIN = -16'sh0145;
	localparam logic signed [TORQ_W-1:0] FIXED_DEFAULT = 16'sh0064;
	localparam int ALARM_A_SLOW_BIT = 15;
	localparam int ALARM_B_BRAKE_BIT = 5;
	localparam int FAULT_D_BRAKE_BIT = 3;
	localparam int CTRL_ON_BIT = 0;
	localparam int CTRL_COAST_BIT = 1;
	localparam int CTRL_RUN_BIT = 3;
	localparam int AUX_B_MEM_CLR_BIT = 13;
	localparam int NUM_AI = 6;
endpackage : bas_pkg
`default_nettype wire

// ### rtl/bas_mismatch_timer.sv
/*
 one mismatch timer: counts continuous disagreement, flags when over the limit.
 assumes limit given in cycles, sampled every clock.
*/
`default_nettype none
module bas_mismatch_timer (
	input wire logic mclk,
	input wire logic rst,
	input wire logic active,
	input wire logic differ,
	input wire logic [bas_pkg::CNT_W-1:0] limit,
	output logic expired
);
	logic [bas_pkg::CNT_W-1:0] cnt_reg, cnt_next;
	always_comb begin
		cnt_next = cnt_reg;
		if (!(active && differ))
			cnt_next = '0;
		else if (cnt_reg <= limit)
			cnt_next = cnt_reg + 1'b1;
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end
	// longer than the limit: one cycle past it
	assign expired = active && differ && (cnt_reg > limit);
endmodule : bas_mismatch_timer
`default_nettype wire

// ### rtl/bas_supervisor.sv
/*
 brake acknowledge supervisor with start-torque source selection.
 assumes all inputs synchronous to mclk; brake alarm and fault flags are cleared by fault_reset, slow alarm by on/coast low.
*/
// How it works
// - reaction chosen by setting, fault after reset
// - setting 0: brake alarm only, no trip
// - setting 1: trip and set brake fault
// - crane: open trips, close gives slow alarm
// - slow alarm: zero speed until on/coast low
// - open mismatch beyond open time raises reaction
// - close mismatch beyond close time raises reaction
// - selector codes: off, memory, fixed, six inputs
// - memory torque never below fixed magnitude
// - aux bit 13 clears stored torque memory
// - fixed torque clamped to +/-325, default 100
// - run start: zero speed, start torque, delay
`default_nettype none
module bas_supervisor (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cfg_load,
	input wire logic [1:0] brake_fault_reaction_sel,
	input wire logic [3:0] start_torque_sel,
	input wire logic signed [bas_pkg::TORQ_W-1:0] fixed_start_torque,
	input wire logic [bas_pkg::TIME_W-1:0] open_mismatch_time,
	input wire logic [bas_pkg::TIME_W-1:0] close_mismatch_time,
	input wire logic [bas_pkg::TIME_W-1:0] brake_reference_delay,
	input wire logic brake_open_cmd,
	input wire logic brake_ack_input,
	input wire logic [15:0] main_control_flags,
	input wire logic [15:0] effective_control_flags,
	input wire logic [15:0] aux_control_flags_b,
	input wire logic fault_reset,
	input wire logic torque_store,
	input wire logic signed [bas_pkg::TORQ_W-1:0] torque_actual,
	input wire logic [6*bas_pkg::TORQ_W-1:0] analog_in,
	output logic [15:0] alarm_flags_a,
	output logic [15:0] alarm_flags_b,
	output logic [15:0] fault_flags_d,
	output logic trip,
	output logic speed_ref_zero,
	output logic speed_ctrl_hold,
	output logic torque_ref_override,
	output logic signed [bas_pkg::TORQ_W-1:0] start_torque
);
	localparam logic [bas_pkg::CNT_W-1:0] TENTH =
		bas_pkg::CNT_W'(bas_pkg::TENTH_S_CYCLES);
	bas_pkg::bas_react_e react_reg, react_next;
	logic signed [bas_pkg::TORQ_W-1:0] fixed_reg, fixed_next;
	logic [3:0] sel_reg, sel_next;
	logic brake_alarm_reg, brake_alarm_next;
	logic brake_fault_reg, brake_fault_next;
	logic slow_reg, slow_next;
	logic signed [bas_pkg::TORQ_W-1:0] mem_reg, mem_next;
	logic signed [bas_pkg::TORQ_W-1:0] st_reg, st_next;
	logic [bas_pkg::CNT_W-1:0] dly_reg, dly_next;
	logic run_d_reg, run_d_next;
	logic szero_reg, szero_next, hold_reg, hold_next, ovr_reg, ovr_next;
	logic open_exp, close_exp, run, on_ok;
	logic signed [bas_pkg::TORQ_W-1:0] ai [bas_pkg::NUM_AI];
	logic signed [bas_pkg::TORQ_W-1:0] fixed_abs, mem_sel;

	genvar gi;
	generate
		for (gi = 0; gi < bas_pkg::NUM_AI; gi++) begin : g_ai
			assign ai[gi] = analog_in[gi*bas_pkg::TORQ_W +: bas_pkg::TORQ_W];
		end
	endgenerate

	bas_mismatch_timer u_open (
		.mclk(mclk),
		.rst(rst),
		.active(brake_open_cmd),
		.differ(brake_open_cmd != brake_ack_input),
		.limit(bas_pkg::CNT_W'(open_mismatch_time) * TENTH),
		.expired(open_exp)
	);
	bas_mismatch_timer u_close (
		.mclk(mclk),
		.rst(rst),
		.active(!brake_open_cmd),
		.differ(brake_open_cmd != brake_ack_input),
		.limit(bas_pkg::CNT_W'(close_mismatch_time) * TENTH),
		.expired(close_exp)
	);

	assign run = main_control_flags[bas_pkg::CTRL_RUN_BIT];
	assign on_ok = effective_control_flags[bas_pkg::CTRL_ON_BIT] &&
		effective_control_flags[bas_pkg::CTRL_COAST_BIT];
	assign fixed_abs = fixed_reg[bas_pkg::TORQ_W-1] ? -fixed_reg : fixed_reg;

	always_comb begin
		react_next = react_reg;
		fixed_next = fixed_reg;
		sel_next = sel_reg;
		if (cfg_load) begin
			react_next = bas_pkg::bas_react_e'(brake_fault_reaction_sel);
			if (react_next == bas_pkg::BAS_RSVD)
				react_next = react_reg;
			if (fixed_start_torque > bas_pkg::FIXED_MAX)
				fixed_next = bas_pkg::FIXED_MAX;
			else if (fixed_start_torque < bas_pkg::FIXED_MIN)
				fixed_next = bas_pkg::FIXED_MIN;
			else
				fixed_next = fixed_start_torque;
			// codes above the last input are ignored
			if (start_torque_sel <= bas_pkg::SEL_AI6)
				sel_next = start_torque_sel;
		end
	end

	always_comb begin
		brake_alarm_next = brake_alarm_reg;
		brake_fault_next = brake_fault_reg;
		slow_next = slow_reg;
		if (fault_reset) begin
			brake_alarm_next = 1'b0;
			brake_fault_next = 1'b0;
		end
		if (!on_ok)
			slow_next = 1'b0;
		// a new event wins over a same-cycle reset
		case (react_reg)
			bas_pkg::BAS_ALARM: begin
				if (open_exp || close_exp)
					brake_alarm_next = 1'b1;
			end
			bas_pkg::BAS_FAULT: begin
				if (open_exp || close_exp)
					brake_fault_next = 1'b1;
			end
			bas_pkg::BAS_CRANE: begin
				if (open_exp)
					brake_fault_next = 1'b1;
				if (close_exp && on_ok)
					slow_next = 1'b1;
			end
			default: begin
				brake_fault_next = brake_fault_reg;
			end
		endcase
	end

	always_comb begin
		mem_next = mem_reg;
		if (torque_store)
			mem_next = torque_actual;
		if (aux_control_flags_b[bas_pkg::AUX_B_MEM_CLR_BIT])
			mem_next = '0;
		// magnitude floor keeps the sign of the stored torque
		if (mem_reg[bas_pkg::TORQ_W-1])
			mem_sel = (-mem_reg < fixed_abs) ? -fixed_abs : mem_reg;
		else
			mem_sel = (mem_reg < fixed_abs) ? fixed_abs : mem_reg;
		case (sel_reg)
			bas_pkg::SEL_OFF: st_next = '0;
			bas_pkg::SEL_MEMORY: st_next = mem_sel;
			bas_pkg::SEL_FIXED: st_next = fixed_reg;
			default: begin
				if (sel_reg >= bas_pkg::SEL_AI1 && sel_reg <= bas_pkg::SEL_AI6)
					st_next = ai[3'(sel_reg - bas_pkg::SEL_AI1)];
				else
					st_next = '0;
			end
		endcase
	end

	always_comb begin
		run_d_next = run;
		dly_next = dly_reg;
		if (run && !run_d_reg)
			dly_next = bas_pkg::CNT_W'(brake_reference_delay) * TENTH;
		else if (!run)
			dly_next = '0;
		else if (dly_reg != '0)
			dly_next = dly_reg - 1'b1;
		ovr_next = run && (dly_next != '0);
		szero_next = ovr_next || slow_next;
		hold_next = ovr_next || slow_next;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			react_reg <= bas_pkg::bas_react_e'(bas_pkg::REACT_RESET);
			fixed_reg <= bas_pkg::FIXED_DEFAULT;
			sel_reg <= bas_pkg::SEL_OFF;
			brake_alarm_reg <= 1'b0;
			brake_fault_reg <= 1'b0;
			slow_reg <= 1'b0;
			mem_reg <= '0;
			st_reg <= '0;
			dly_reg <= '0;
			run_d_reg <= 1'b0;
			ovr_reg <= 1'b0;
			szero_reg <= 1'b0;
			hold_reg <= 1'b0;
		end else begin
			react_reg <= react_next;
			fixed_reg <= fixed_next;
			sel_reg <= sel_next;
			brake_alarm_reg <= brake_alarm_next;
			brake_fault_reg <= brake_fault_next;
			slow_reg <= slow_next;
			mem_reg <= mem_next;
			st_reg <= st_next;
			dly_reg <= dly_next;
			run_d_reg <= run_d_next;
			ovr_reg <= ovr_next;
			szero_reg <= szero_next;
			hold_reg <= hold_next;
		end
	end

	always_comb begin
		alarm_flags_a = '0;
		alarm_flags_a[bas_pkg::ALARM_A_SLOW_BIT] = slow_reg;
		alarm_flags_b = '0;
		alarm_flags_b[bas_pkg::ALARM_B_BRAKE_BIT] = brake_alarm_reg;
		fault_flags_d = '0;
		fault_flags_d[bas_pkg::FAULT_D_BRAKE_BIT] = brake_fault_reg;
	end
	assign trip = brake_fault_reg;
	assign speed_ref_zero = szero_reg;
	assign speed_ctrl_hold = hold_reg;
	assign torque_ref_override = ovr_reg;
	assign start_torque = st_reg;
endmodule : bas_supervisor
`default_nettype wire

// ### verification/bas_checker.sv
/* port assertions for the brake supervisor.
 bound from tb_top; mismatch limits are zero in the bench. */
`default_nettype none
module bas_checker (
	input wire logic mclk,
	input wire logic rst,
	input wire logic brake_open_cmd,
	input wire logic brake_ack_input,
	input wire logic fault_reset,
	input wire logic [15:0] effective_control_flags,
	input wire logic [15:0] alarm_flags_a,
	input wire logic [15:0] alarm_flags_b,
	input wire logic [15:0] fault_flags_d,
	input wire logic trip,
	input wire logic speed_ref_zero,
	input wire logic speed_ctrl_hold
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	wire logic differ = brake_open_cmd ^ brake_ack_input;
	wire logic run_ok = effective_control_flags[0] & effective_control_flags[1];
	trip_fault_a: assert property (trip == fault_flags_d[3]) else $error("trip off");
	alarm_cause_a: assert property ($rose(alarm_flags_b[5]) |-> $past(differ) &&
		$past(differ, 2)) else $error("alarm without mismatch");
	fault_cause_a: assert property ($rose(fault_flags_d[3]) |-> $past(differ) &&
		$past(differ, 2)) else $error("fault without mismatch");
	slow_cause_a: assert property ($rose(alarm_flags_a[15]) |->
		$past(!brake_open_cmd && brake_ack_input && run_ok)) else $error("slow alarm cause");
	slow_zero_a: assert property ($past(alarm_flags_a[15]) && alarm_flags_a[15] |->
		speed_ref_zero && speed_ctrl_hold) else $error("speed not held");
	slow_drop_a: assert property (alarm_flags_a[15] && !run_ok |->
		##[1:2] !alarm_flags_a[15]) else $error("slow alarm stuck");
	alarm_hold_a: assert property (alarm_flags_b[5] && !fault_reset |=> alarm_flags_b[5])
		else $error("alarm lost");
	fault_hold_a: assert property (fault_flags_d[3] && !fault_reset |=> fault_flags_d[3])
		else $error("fault lost");
	alarm_clear_a: assert property (fault_reset && !differ |=> !alarm_flags_b[5])
		else $error("alarm not cleared");
endmodule : bas_checker
`default_nettype wire

// ### verification/bas_partner.sv
/* brake contact: acknowledge follows the open command one or two cycles late.
 bench sets slow for the longer lag and stuck to freeze a worn contact. */
`default_nettype none
module bas_partner (
	input wire logic mclk,
	input wire logic rst,
	input wire logic brake_open_cmd,
	input wire logic slow,
	input wire logic stuck,
	output logic brake_ack_input
);
	logic mid_reg;
	logic ack_reg;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mid_reg <= 1'b0;
			ack_reg <= 1'b0;
		end else if (!stuck) begin
			mid_reg <= brake_open_cmd;
			ack_reg <= slow ? mid_reg : brake_open_cmd;
		end
	end
	assign brake_ack_input = ack_reg;
endmodule : bas_partner
`default_nettype wire

// ### verification/tb_top.sv
/* self-checking bench for the brake supervisor.
 all mismatch times are zero so limits are reached in two cycles. */
`default_nettype none
`define CMP(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {int ch; logic [15:0] v;} bas_note_s;
	logic mclk, rst, cfg_load, cmd, ack, fault_reset, torque_store, slow, stuck;
	logic trip, srz, hold, ovr;
	logic [9:0] rdly;
	logic [1:0] rsel;
	logic [3:0] tsel;
	logic signed [15:0] fx, tact, stq;
	logic [15:0] eff, aux, fa, fb, fd, mcf;
	logic [95:0] ain;
	logic [31:0] seed = 32'h2A77B7A7;
	int n_mismatch, n_compared;
	bas_note_s q[$];
	event look;
	bas_supervisor bas_supervisor_inst (.mclk(mclk), .rst(rst), .cfg_load(cfg_load),
		.brake_fault_reaction_sel(rsel), .start_torque_sel(tsel), .fixed_start_torque(fx),
		.open_mismatch_time(10'h000), .close_mismatch_time(10'h000),
		.brake_reference_delay(rdly), .brake_open_cmd(cmd), .brake_ack_input(ack),
		.main_control_flags(mcf), .effective_control_flags(eff),
		.aux_control_flags_b(aux), .fault_reset(fault_reset), .torque_store(torque_store),
		.torque_actual(tact), .analog_in(ain), .alarm_flags_a(fa), .alarm_flags_b(fb),
		.fault_flags_d(fd), .trip(trip), .speed_ref_zero(srz), .speed_ctrl_hold(hold),
		.torque_ref_override(ovr), .start_torque(stq));
	bas_partner bas_partner_inst (.mclk(mclk), .rst(rst), .brake_open_cmd(cmd),
		.slow(slow), .stuck(stuck), .brake_ack_input(ack));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask : tick
	task automatic note(input int ch, input logic [15:0] v);
		q.push_back('{ch, v});
		-> look;
	endtask : note
	task automatic cfg(input logic [1:0] r, input logic [3:0] s, input logic [15:0] f);
		rsel = r;
		tsel = s;
		fx = f;
		cfg_load = 1'b1;
		tick(1);
		cfg_load = 1'b0;
		tick(2);
	endtask : cfg
	task automatic final_report();
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin : monitor
		bas_note_s n;
		logic [15:0] got;
		forever begin
			@(look);
			n = q.pop_front();
			got = n.ch == 0 ? {9'h0, ovr, fa[15], fb[5], fd[3], trip, srz, hold} : stq;
			`CMP(got, n.v)
		end
	end
	initial begin
		#100000;
		n_mismatch++;
		final_report();
	end
	initial begin : main_seq
		logic [1:0] rs [4];
		logic a, b, f;
		logic signed [15:0] lim, e;
		rs = '{2'h1, 2'h0, 2'h3, 2'h2};
		{rst, cfg_load, cmd, fault_reset, torque_store, slow, stuck} = 7'h40;
		{rsel, tsel, fx, tact, aux, ain, mcf, rdly} = '0;
		eff = 16'h0003;
		tick(4);
		rst = 1'b0;
		// reaction 2 is ignored, so the last row still behaves as crane
		foreach (rs[i]) for (int d = 1; d >= 0; d--) begin
			if (i > 0) cfg(rs[i], 4'h0, 16'h0064);
			a = rs[i][1] & !d;
			b = rs[i] == 2'h0;
			f = rs[i] == 2'h1 || (rs[i][1] && d);
			cmd = !d;
			tick(3);
			stuck = 1'b1;
			cmd = d;
			tick(5);
			note(0, {10'h0, a, b, f, f, a, a});
			stuck = 1'b0;
			eff = 16'h0000;
			fault_reset = 1'b1;
			tick(2);
			eff = 16'h0003;
			fault_reset = 1'b0;
			tick(3);
			note(0, 16'h0000);
		end
		for (int c = 0; c < 10; c++) begin
			seed = xs(seed);
			ain = {seed, ~seed, seed};
			cfg(2'h1, c[3:0], seed[25:10]);
			lim = fx > bas_pkg::FIXED_MAX ? bas_pkg::FIXED_MAX : fx;
			lim = lim < bas_pkg::FIXED_MIN ? bas_pkg::FIXED_MIN : lim;
			case (c)
				0: e = 16'sh0000;
				1: e = lim < 0 ? -lim : lim;
				2: e = lim;
				default: e = ain[(c > 8 ? 5 : c - 3) * 16 +: 16];
			endcase
			note(1, e);
		end
		// clearing after a large store proves the clear, then a small store meets the floor
		cfg(2'h1, 4'h1, 16'h0064);
		for (int m = 0; m < 3; m++) begin
			tact = m == 0 ? -16'sh0200 : 16'sh0010;
			torque_store = m != 1;
			aux[13] = m == 1;
			tick(1);
			{torque_store, aux} = '0;
			tick(2);
			note(1, m == 0 ? -16'sh0200 : 16'sh0064);
		end
		cfg(2'h0, 4'h0, 16'h0064);
		for (int s = 0; s < 2; s++) begin
			slow = s;
			cmd = 1'b1;
			tick(4);
			note(0, {11'h0, s[0], 4'h0});
			cmd = 1'b0;
			tick(3);
			fault_reset = 1'b1;
			tick(1);
			fault_reset = 1'b0;
		end
		// a delay far longer than the run, so only dropping run can end the start phase
		rdly = 10'h001;
		mcf = 16'h0008;
		tick(2);
		note(0, 16'h0043);
		mcf = 16'h0000;
		tick(2);
		note(0, 16'h0000);
		tick(2);
		final_report();
	end
endmodule : tb_top
bind bas_supervisor bas_checker bas_checker_inst (.mclk(mclk), .rst(rst),
	.brake_open_cmd(brake_open_cmd), .brake_ack_input(brake_ack_input),
	.fault_reset(fault_reset), .effective_control_flags(effective_control_flags),
	.alarm_flags_a(alarm_flags_a), .alarm_flags_b(alarm_flags_b),
	.fault_flags_d(fault_flags_d), .trip(trip), .speed_ref_zero(speed_ref_zero),
	.speed_ctrl_hold(speed_ctrl_hold));
`default_nettype wire
